// >>> rtl/dcws_direction.sv
// direction handling of a signed reference for one location setting
`timescale 1ns/1ps
module dcws_direction
	import dcws_pkg::*;
#(
	parameter int W = 20
) (
	input  wire logic signed [W-1:0] val_i,
	input  wire logic        [1:0]   dir_i,
	output logic             signed [W-1:0] val_o
);
	// an unused code 0 gives zero, the safe choice for a motor
	always_comb begin
		unique case (dir_i)
			DIR_FWD: val_o = (val_i < 0) ? '0 : val_i;
			DIR_REV: val_o = (val_i < 0) ? val_i : -val_i;
			DIR_REQ: val_o = val_i;
			default: val_o = '0;
		endcase
	end
endmodule // dcws_direction

// >>> rtl/dcws_pkg.sv
// shared constants and types for the drive control word sequencer
package dcws_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_PSET   = 8'h08;
	localparam logic [7:0] OFS_SSET   = 8'h0C;
	localparam logic [7:0] OFS_CEIL1  = 8'h10;
	localparam logic [7:0] OFS_CEIL2  = 8'h14;
	localparam logic [7:0] OFS_FLOOR1 = 8'h18;
	localparam logic [7:0] OFS_FLOOR2 = 8'h1C;
	localparam logic [7:0] OFS_SLIM   = 8'h20;
	localparam logic [7:0] OFS_CTRL   = 8'h24;
	localparam logic [7:0] OFS_PREF   = 8'h28;
	localparam logic [7:0] OFS_SREF   = 8'h2C;

	// command word values of the start sequence
	localparam logic [15:0] CW_ARM    = 16'h0006;
	localparam logic [15:0] CW_PRIME  = 16'h0007;
	localparam logic [15:0] CW_ENABLE = 16'h000F;
	localparam logic [15:0] CW_ACCEL  = 16'h002F;
	localparam logic [15:0] CW_FOLLOW = 16'h006F;
	localparam int          CW_FAULT_RESET_BIT = 7;

	// setpoint scaling: counts that stand for full scale
	localparam int          PRIMARY_FULL   = 20000;
	localparam int          SECONDARY_FULL = 10000;
	localparam logic signed [17:0] SUM_OFFSET = 18'sh02710; // half of primary full scale
	localparam logic signed [17:0] SP_MAX     = 18'sh07FFF;
	localparam logic signed [17:0] SP_MIN     = -18'sh07FFF;

	// direction codes
	localparam logic [1:0] DIR_FWD = 2'h1;
	localparam logic [1:0] DIR_REV = 2'h2;
	localparam logic [1:0] DIR_REQ = 2'h3;

	// reset values
	localparam logic [15:0] RST_CEIL = 16'h0000;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// settle time after arming, for status only
	localparam int ARM_WAIT_MS     = 100;
	localparam int CLK_MHZ         = 200;
	localparam int ARM_WAIT_CYCLES = ARM_WAIT_MS * 1000 * CLK_MHZ;

	// drive states, one-hot
	typedef enum logic [6:0] {
		ST_NOT_READY = 7'h01,
		ST_ARMED     = 7'h02,
		ST_PRIMED    = 7'h04,
		ST_ENABLED   = 7'h08,
		ST_ACCEL     = 7'h10,
		ST_FOLLOWING = 7'h20,
		ST_FAULT     = 7'h40
	} dcws_state_t;

	// control register layout
	typedef struct packed {
		logic       use_two;
		logic [1:0] dir_two;
		logic [1:0] dir_one;
		logic       sum_en;
	} dcws_ctrl_t;

	localparam dcws_ctrl_t RST_CTRL = '{use_two: 1'b0, dir_two: DIR_FWD,
		dir_one: DIR_FWD, sum_en: 1'b0};

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] wr, input logic [1:0] sel);
		merge16 = {sel[1] ? wr[15:8] : old[15:8], sel[0] ? wr[7:0] : old[7:0]};
	endfunction
endpackage

// >>> rtl/dcws_scaler.sv
// setpoint scaler: counts to output units against a ceiling, optional clamp
`timescale 1ns/1ps
module dcws_scaler
	import dcws_pkg::*;
#(
	parameter int FULL  = PRIMARY_FULL,
	parameter int OUT_W = 20
) (
	input  wire logic signed [17:0]      sp_i,
	input  wire logic        [15:0]      ceil_i,
	input  wire logic        [15:0]      lim_i,
	input  wire logic                    clamp_i,
	output logic             signed [OUT_W-1:0] ref_o
);
	logic signed [35:0] prod;
	logic signed [35:0] quo;
	logic signed [35:0] lim;

	// floors never enter here: only the ceiling sets the scale
	always_comb begin
		prod = 36'(sp_i) * $signed({20'h00000, ceil_i});
		quo  = prod / $signed(36'(FULL));
		lim  = $signed({20'h00000, lim_i});
		if (clamp_i && quo > lim) begin
			ref_o = OUT_W'(lim);
		end else if (clamp_i && quo < -lim) begin
			ref_o = OUT_W'(-lim);
		end else begin
			ref_o = OUT_W'(quo);
		end
	end
endmodule // dcws_scaler

// >>> rtl/dcws_top.sv
// command word sequencer and setpoint path behind a wishbone slave
// Behaviour
// - after power-up the drive sits in not-ready until a valid command sequence
// - command word 0x0006 moves the drive to the armed state
// - command word 0x0007 moves armed to primed
// - command word 0x000F enables modulation while the ramp is held
// - command word 0x002F releases the ramp generator output, accelerator enabled
// - command word 0x006F enters following state, tracking the setpoint
// - fault reset from a digital input does the same transition as bus reset
// - primary setpoint signed, 20000 counts equal full primary ceiling
// - secondary setpoint 10000 counts equal full ceiling, then clamped to limit
// - floor settings never affect setpoint scaling, only ceilings do
// - sum mode adds analogue percentage minus half primary full scale
// - setpoints are bipolar; negative values go to direction handling
// - each external location has its own direction code 1, 2 or 3
`timescale 1ns/1ps
module dcws_top
	import dcws_pkg::*;
#(
	parameter int WAIT_CYCLES = ARM_WAIT_CYCLES
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                fault_i,
	input  wire logic                fault_reset_i,
	input  wire logic signed [15:0]  analog_i,
	output dcws_state_t              state_o,
	output logic                     modulate_o,
	output logic                     ramp_hold_o,
	output logic                     ramp_release_o,
	output logic                     follow_o,
	output logic signed [19:0]       primary_ref_o,
	output logic signed [19:0]       secondary_ref_o
);
	localparam int CNT_W = $clog2(WAIT_CYCLES + 1);

	dcws_state_t       state;
	dcws_ctrl_t        ctrl;
	logic [15:0]       command_word;
	logic [15:0]       pset;
	logic [15:0]       sset;
	logic [15:0]       ceil1;
	logic [15:0]       ceil2;
	logic [15:0]       floor1;
	logic [15:0]       floor2;
	logic [15:0]       slim;
	logic [CNT_W-1:0]  wait_cnt;
	logic              wait_done;
	logic              req;
	logic              wr_fire;
	logic              cmd_fire;
	logic [15:0]       cmd_val;
	logic [15:0]       wr16;
	logic [1:0]        dir_act;
	logic signed [17:0] sum_raw;
	logic signed [17:0] prim_in;
	logic signed [17:0] sec_in;
	logic signed [19:0] prim_scaled;
	logic signed [19:0] sec_scaled;
	logic signed [19:0] prim_dir;
	logic signed [19:0] sec_dir;

	// bus request decode; the write lands on the edge that raises ack
	assign req      = wb_cyc_i && wb_stb_i;
	assign wr_fire  = req && wb_we_i && !wb_ack_o;
	assign wr16     = wb_dat_i[15:0];
	assign cmd_val  = merge16(command_word, wr16, wb_sel_i[1:0]);
	assign cmd_fire = wr_fire && wb_adr_i == OFS_CMD;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req && !wb_ack_o;
		end
	end

	// writable registers; floors are stored for software but feed no math
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			command_word <= RST_WORD;
			pset         <= RST_WORD;
			sset         <= RST_WORD;
			ceil1        <= RST_CEIL;
			ceil2        <= RST_CEIL;
			floor1       <= RST_WORD;
			floor2       <= RST_WORD;
			slim         <= RST_CEIL;
			ctrl         <= RST_CTRL;
		end else if (wr_fire) begin
			unique case (wb_adr_i)
				OFS_CMD:    command_word <= cmd_val;
				OFS_PSET:   pset   <= merge16(pset, wr16, wb_sel_i[1:0]);
				OFS_SSET:   sset   <= merge16(sset, wr16, wb_sel_i[1:0]);
				OFS_CEIL1:  ceil1  <= merge16(ceil1, wr16, wb_sel_i[1:0]);
				OFS_CEIL2:  ceil2  <= merge16(ceil2, wr16, wb_sel_i[1:0]);
				OFS_FLOOR1: floor1 <= merge16(floor1, wr16, wb_sel_i[1:0]);
				OFS_FLOOR2: floor2 <= merge16(floor2, wr16, wb_sel_i[1:0]);
				OFS_SLIM:   slim   <= merge16(slim, wr16, wb_sel_i[1:0]);
				OFS_CTRL: begin
					if (wb_sel_i[0]) begin
						ctrl <= dcws_ctrl_t'(wb_dat_i[5:0]);
					end
				end
				default: ;
			endcase
		end
	end

	// read mux, registered with ack; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req && !wb_ack_o) begin
			unique case (wb_adr_i)
				OFS_CMD:    wb_dat_o <= {16'h0000, command_word};
				OFS_STATUS: wb_dat_o <= {24'h000000, wait_done, state};
				OFS_PSET:   wb_dat_o <= {16'h0000, pset};
				OFS_SSET:   wb_dat_o <= {16'h0000, sset};
				OFS_CEIL1:  wb_dat_o <= {16'h0000, ceil1};
				OFS_CEIL2:  wb_dat_o <= {16'h0000, ceil2};
				OFS_FLOOR1: wb_dat_o <= {16'h0000, floor1};
				OFS_FLOOR2: wb_dat_o <= {16'h0000, floor2};
				OFS_SLIM:   wb_dat_o <= {16'h0000, slim};
				OFS_CTRL:   wb_dat_o <= {26'h0000000, ctrl};
				OFS_PREF:   wb_dat_o <= 32'(primary_ref_o);
				OFS_SREF:   wb_dat_o <= 32'(secondary_ref_o);
				default:    wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// drive state machine; a fault input overrides any command
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_NOT_READY;
		end else if (fault_i) begin
			state <= ST_FAULT;
		end else if (state == ST_FAULT) begin
			// bus bit or digital input, same transition either way
			if (fault_reset_i || (cmd_fire && cmd_val[CW_FAULT_RESET_BIT])) begin
				state <= ST_NOT_READY;
			end
		end else if (cmd_fire) begin
			case (cmd_val)
				CW_ARM: state <= ST_ARMED;
				CW_PRIME: begin
					if (state == ST_ARMED) begin
						state <= ST_PRIMED;
					end
				end
				CW_ENABLE: begin
					if (state == ST_PRIMED) begin
						state <= ST_ENABLED;
					end
				end
				CW_ACCEL: begin
					if (state == ST_ENABLED) begin
						state <= ST_ACCEL;
					end
				end
				CW_FOLLOW: begin
					if (state == ST_ACCEL) begin
						state <= ST_FOLLOWING;
					end
				end
				default: ;
			endcase
		end
	end

	// settle counter while armed; status only, the master owns the wait
	always_ff @(posedge clk_i) begin
		if (rst_i || state != ST_ARMED) begin
			wait_cnt  <= '0;
			wait_done <= 1'b0;
		end else if (wait_cnt != CNT_W'(WAIT_CYCLES)) begin
			wait_cnt  <= wait_cnt + CNT_W'(1);
		end else begin
			wait_done <= 1'b1;
		end
	end

	// drive outputs follow the state one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_o        <= ST_NOT_READY;
			modulate_o     <= 1'b0;
			ramp_hold_o    <= 1'b0;
			ramp_release_o <= 1'b0;
			follow_o       <= 1'b0;
		end else begin
			state_o        <= state;
			modulate_o     <= state inside {ST_ENABLED, ST_ACCEL, ST_FOLLOWING};
			ramp_hold_o    <= state == ST_ENABLED;
			ramp_release_o <= state inside {ST_ACCEL, ST_FOLLOWING};
			follow_o       <= state == ST_FOLLOWING;
		end
	end

	// sum mode correction, saturated to the legal setpoint span
	assign sum_raw = 18'($signed(pset)) + 18'(analog_i) - SUM_OFFSET;
	always_comb begin
		if (!ctrl.sum_en) begin
			prim_in = 18'($signed(pset));
		end else if (sum_raw > SP_MAX) begin
			prim_in = SP_MAX;
		end else if (sum_raw < SP_MIN) begin
			prim_in = SP_MIN;
		end else begin
			prim_in = sum_raw;
		end
	end
	assign sec_in  = 18'($signed(sset));
	assign dir_act = ctrl.use_two ? ctrl.dir_two : ctrl.dir_one;

	dcws_scaler #(.FULL(PRIMARY_FULL), .OUT_W(20)) u_prim_scale (
		.sp_i    (prim_in),
		.ceil_i  (ceil1),
		.lim_i   (RST_CEIL),
		.clamp_i (1'b0),
		.ref_o   (prim_scaled)
	);

	dcws_scaler #(.FULL(SECONDARY_FULL), .OUT_W(20)) u_sec_scale (
		.sp_i    (sec_in),
		.ceil_i  (ceil2),
		.lim_i   (slim),
		.clamp_i (1'b1),
		.ref_o   (sec_scaled)
	);

	dcws_direction #(.W(20)) u_prim_dir (
		.val_i (prim_scaled),
		.dir_i (dir_act),
		.val_o (prim_dir)
	);

	dcws_direction #(.W(20)) u_sec_dir (
		.val_i (sec_scaled),
		.dir_i (dir_act),
		.val_o (sec_dir)
	);

	// one register stage keeps the references glitch free at the pins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			primary_ref_o   <= '0;
			secondary_ref_o <= '0;
		end else begin
			primary_ref_o   <= prim_dir;
			secondary_ref_o <= sec_dir;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_cmd(logic [15:0] v);
		cmd_fire && cmd_val == v && !fault_i && state != ST_FAULT;
	endsequence

	property p_reset_idle;
		$past(rst_i) |-> state == ST_NOT_READY && !modulate_o;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");

	property p_arm;
		s_cmd(CW_ARM) |=> state == ST_ARMED ##1 state_o == ST_ARMED;
	endproperty
	a_arm: assert property (p_arm) else $error("arm command not taken");

	property p_prime;
		(state == ST_ARMED) ##0 s_cmd(CW_PRIME) |=> state == ST_PRIMED;
	endproperty
	a_prime: assert property (p_prime) else $error("prime command not taken");

	property p_enable_hold;
		(state == ST_PRIMED) ##0 s_cmd(CW_ENABLE) |=> ##1 modulate_o && ramp_hold_o
			&& !ramp_release_o;
	endproperty
	a_enable_hold: assert property (p_enable_hold) else $error("enable without hold");

	property p_accel;
		(state == ST_ENABLED) ##0 s_cmd(CW_ACCEL) |=> state == ST_ACCEL
			##1 ramp_release_o && !ramp_hold_o;
	endproperty
	a_accel: assert property (p_accel) else $error("ramp not released");

	property p_follow;
		(state == ST_ACCEL) ##0 s_cmd(CW_FOLLOW) |=> ##1 follow_o && modulate_o;
	endproperty
	a_follow: assert property (p_follow) else $error("following not entered");

	property p_input_reset;
		state == ST_FAULT && fault_reset_i && !fault_i |=> state == ST_NOT_READY;
	endproperty
	a_input_reset: assert property (p_input_reset) else $error("input reset ignored");

	property p_full_scale;
		prim_in == 18'sh04E20 && dir_act == DIR_REQ |=>
			primary_ref_o == $signed({4'h0, $past(ceil1)});
	endproperty
	a_full_scale: assert property (p_full_scale) else $error("primary scale wrong");

	property p_sec_clamp;
		!$past(rst_i) |-> secondary_ref_o <= $signed({4'h0, $past(slim)})
			&& secondary_ref_o >= -$signed({4'h0, $past(slim)});
	endproperty
	a_sec_clamp: assert property (p_sec_clamp) else $error("secondary not clamped");

	property p_sum_mid;
		ctrl.sum_en && pset == 16'h0000 && analog_i == 16'sh2710 |-> prim_in == 18'sh00000;
	endproperty
	a_sum_mid: assert property (p_sum_mid) else $error("sum offset wrong");

	property p_fwd_block;
		dir_act == DIR_FWD && prim_scaled < 0 |=> primary_ref_o == 20'sh00000;
	endproperty
	a_fwd_block: assert property (p_fwd_block) else $error("forward passed negative");

	property p_loc_two;
		ctrl.use_two && ctrl.dir_two == DIR_REV && prim_scaled > 0 |=> primary_ref_o < 0;
	endproperty
	a_loc_two: assert property (p_loc_two) else $error("location two ignored");
endmodule // dcws_top

// >>> tb/dcws_fb_master.sv
// wishbone master model standing in for the fieldbus controller
`timescale 1ns/1ps
module dcws_fb_master
	import dcws_pkg::*;
#(
	parameter int WAIT = ARM_WAIT_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic      [7:0]  adr_o,
	output logic      [3:0]  sel_o,
	output logic      [31:0] dat_o
);
	// idle bus from time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0000_0000;
	end

	// one classic cycle, held until ack is seen high at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic ok);
		int n;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		sel_o <= 4'h3;
		dat_o <= d;
		ok = 1'b0;
		n = 0;
		r = 32'h0000_0000;
		while (!ok && n < 64) begin
			@(posedge clk_i);
			n++;
			if (ack_i === 1'b1) begin
				ok = 1'b1;
				r = dat_i;
			end
		end
		// released lines show the inverse so a stale copy is never trusted
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o  <= ~w;
		adr_o <= ~a;
		dat_o <= ~d;
	endtask

	// hold off after arming; the next command must not come early
	task automatic settle();
		repeat (WAIT + 2) @(posedge clk_i);
	endtask
endmodule // dcws_fb_master

// >>> tb/dcws_top_tb.sv
// self-checking bench for the drive control word sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("wrong value at %0t: got %0h expected %0h", $time, g, e); \
	end \
end
module dcws_top_tb
	import dcws_pkg::*;
;
	localparam int WAIT = 20;
	logic               clk_i;
	logic               rst_i;
	logic               fault_i;
	logic               fault_reset_i;
	logic               wb_cyc_i;
	logic               wb_stb_i;
	logic               wb_we_i;
	logic               wb_ack_o;
	logic        [7:0]  wb_adr_i;
	logic        [3:0]  wb_sel_i;
	logic        [31:0] wb_dat_i;
	logic        [31:0] wb_dat_o;
	logic        [31:0] q;
	logic signed [15:0] analog_i;
	dcws_state_t        state_o;
	logic               modulate_o;
	logic               ramp_hold_o;
	logic               ramp_release_o;
	logic               follow_o;
	logic signed [19:0] primary_ref_o;
	logic signed [19:0] secondary_ref_o;
	logic signed [19:0] e;
	int                 error_cnt = 0;
	int                 samples_checked = 0;
	int                 seed = 32'hE70D;

	dcws_top #(.WAIT_CYCLES(WAIT)) dcws_top_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.fault_i(fault_i), .fault_reset_i(fault_reset_i), .analog_i(analog_i),
		.state_o(state_o), .modulate_o(modulate_o), .ramp_hold_o(ramp_hold_o),
		.ramp_release_o(ramp_release_o), .follow_o(follow_o),
		.primary_ref_o(primary_ref_o), .secondary_ref_o(secondary_ref_o)
	);

	dcws_fb_master #(.WAIT(WAIT)) dcws_fb_master_i (
		.clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
		.stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i),
		.dat_o(wb_dat_i)
	);

	// 200 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// counts, verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one bus transfer; a missing answer ends the run
	task automatic go(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic ok;
		dcws_fb_master_i.xfer(w, a, d, q, ok);
		// step off the ack edge so outputs are read where they have settled
		#1;
		if (!ok) begin
			error_cnt++;
			$display("wrong value at %0t: bus answer missing", $time);
			test_done();
		end
	endtask

	// flag pattern each state should show: modulate, hold, release, follow
	function automatic logic [3:0] flags(input dcws_state_t s);
		return {s inside {ST_ENABLED, ST_ACCEL, ST_FOLLOWING}, s == ST_ENABLED,
			s inside {ST_ACCEL, ST_FOLLOWING}, s == ST_FOLLOWING};
	endfunction

	// write a command word, then look at the state one cycle after ack
	task automatic step(input logic [15:0] w, input dcws_state_t s);
		go(1'b1, OFS_CMD, {16'h0000, w});
		@(posedge clk_i);
		#1;
		`CHK(state_o, s)
		`CHK({modulate_o, ramp_hold_o, ramp_release_o, follow_o}, flags(s))
		if (w == CW_ARM && s == ST_ARMED)
			dcws_fb_master_i.settle();
	endtask

	// expected reference: scale by ceiling only, optional clamp, then direction
	function automatic logic signed [19:0] expv(input longint v, input longint c,
		input longint full, input longint lim, input logic cl, input logic [1:0] d);
		longint x;
		x = v * c / full;
		if (cl && x > lim)
			x = lim;
		if (cl && x < -lim)
			x = -lim;
		case (d)
			2'h1: x = (x < 0) ? 0 : x;
			2'h2: x = (x > 0) ? -x : x;
			2'h3: x = x;
			default: x = 0;
		endcase
		return 20'(x);
	endfunction

	initial begin
		logic [15:0] c1;
		logic [15:0] c2;
		logic [15:0] sl;
		logic [15:0] p;
		logic [15:0] s;
		logic [15:0] an;
		logic [5:0]  ct;
		longint      v;
		rst_i = 1'b1;
		fault_i = 1'b0;
		fault_reset_i = 1'b0;
		analog_i = 16'sh0000;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		`CHK(state_o, ST_NOT_READY)
		go(1'b0, OFS_CTRL, 32'h0000_0000);
		`CHK(q, {26'h0, RST_CTRL})
		go(1'b0, 8'h30, 32'hFFFF_FFFF);
		`CHK(q, 32'h0000_0000)
		step(CW_PRIME, ST_NOT_READY);
		step(CW_ARM, ST_ARMED);
		go(1'b0, OFS_STATUS, 32'h0000_0000);
		`CHK(q[7:0], {1'b1, ST_ARMED})
		step(CW_ENABLE, ST_ARMED);
		step(CW_PRIME, ST_PRIMED);
		step(CW_ENABLE, ST_ENABLED);
		step(CW_ACCEL, ST_ACCEL);
		step(CW_FOLLOW, ST_FOLLOWING);
		$display("start sequence test done");
		// fault from the pin; a bus reset must not win while it is high
		@(posedge clk_i);
		fault_i <= 1'b1;
		step(16'h0080, ST_FAULT);
		@(posedge clk_i);
		fault_i <= 1'b0;
		step(CW_ARM, ST_FAULT);
		@(posedge clk_i);
		fault_reset_i <= 1'b1;
		@(posedge clk_i);
		fault_reset_i <= 1'b0;
		@(posedge clk_i);
		#1;
		`CHK(state_o, ST_NOT_READY)
		step(CW_ARM, ST_ARMED);
		@(posedge clk_i);
		fault_i <= 1'b1;
		@(posedge clk_i);
		fault_i <= 1'b0;
		step(16'h0080, ST_NOT_READY);
		$display("fault test done");
		// random setpoints and settings, full-scale corners first
		for (int i = 0; i < 48; i++) begin
			c1 = 16'($random(seed));
			c2 = 16'($random(seed));
			sl = 16'($random(seed));
			ct = 6'($random(seed));
			p  = 16'($random(seed) % 32768);
			s  = 16'($random(seed) % 32768);
			an = 16'($random(seed) % 32768);
			if (i < 6) begin
				p  = i[0] ? 16'h8001 : 16'h7FFF;
				s  = p;
				an = p;
				c1 = 16'hFFFF;
			end
			// sum mode at its midpoint: bus zero plus half scale analogue gives zero
			if (i == 6) begin
				p  = 16'h0000;
				an = 16'h2710;
				ct = 6'h07;
			end
			// exact primary full scale with sign kept, so the output equals the ceiling
			if (i == 7) begin
				p  = 16'h4E20;
				ct = 6'h06;
			end
			@(posedge clk_i);
			analog_i <= an;
			go(1'b1, OFS_CEIL1, {16'h0000, c1});
			go(1'b1, OFS_CEIL2, {16'h0000, c2});
			go(1'b1, OFS_SLIM, {16'h0000, sl});
			go(1'b1, OFS_FLOOR1, 32'($random(seed)));
			go(1'b1, OFS_FLOOR2, 32'($random(seed)));
			go(1'b1, OFS_CTRL, {26'h0, ct});
			go(1'b1, OFS_PSET, {16'h0000, p});
			go(1'b1, OFS_SSET, {16'h0000, s});
			v = longint'($signed(p));
			if (ct[0])
				v = v + longint'($signed(an)) - 10000;
			if (v > 32767)
				v = 32767;
			if (v < -32767)
				v = -32767;
			e = expv(v, c1, PRIMARY_FULL, 0, 1'b0, ct[5] ? ct[4:3] : ct[2:1]);
			go(1'b0, OFS_PREF, 32'h0000_0000);
			`CHK(q, 32'(e))
			`CHK(primary_ref_o, e)
			e = expv($signed(s), c2, SECONDARY_FULL, sl, 1'b1, ct[5] ? ct[4:3] : ct[2:1]);
			go(1'b0, OFS_SREF, 32'h0000_0000);
			`CHK(q, 32'(e))
			`CHK(secondary_ref_o, e)
		end
		$display("setpoint test done");
		test_done();
	end
endmodule // dcws_top_tb
